/* File: hw/srw_pkg.sv */
// Package with constants and types for the supervisor reset watchdog
package srw_pkg;
    localparam int unsigned WD_EXT_MULT     = 500;
    localparam int unsigned WD_INT_PCT      = 94;
    localparam int unsigned PCT_FULL        = 100;
    localparam int unsigned MIN_PULSE_NS    = 30;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned MIN_PULSE_CYC   =
        (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_HOLD_CYC    = 20000;
    localparam int unsigned WD_BASIC_CYC    = 40000;
    localparam int unsigned CNT_W           = 32;
    localparam logic        RST_NB_RESET    = 1'b0;
    typedef enum logic [1:0] {
        SRW_UNDER,
        SRW_HOLD,
        SRW_RUN
    } srw_state_t;
endpackage

/* File: hw/srw_supervisor.sv */
// Supervisor top: supply reset, reset hold timer and watchdog
// Notes on behaviour
// - Missing toggle edge per period causes reset pulse
// - Toggle edge or range change clears timer
// - Timer held zero during reset, restarts after
// - Toggle pulses of 30 ns are recognised
// - Normal range uses basic watchdog period
// - Extended range multiplies period by 500
// - Extended range internal pulse at 94% period
// - Reset asserted while supply below trip
// - Hold period after recovery, then release
// - Watchdog expiry gives one hold-period reset
// - Repeated expiries repeat the reset pulse
// - Active-high reset is inverse of active-low
// - Disabled timing setting prevents watchdog resets
`timescale 1ns/1ps
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned RESET_HOLD_CYCLES = RST_HOLD_CYC,
    parameter int unsigned WD_BASIC_CYCLES   = WD_BASIC_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Supervised conditions
    input  wire logic supply_below_trip,
    input  wire logic watchdog_toggle_in,
    input  wire logic toggle_floating,
    input  wire logic timeout_range_select,
    input  wire logic watchdog_timing_setting,
    // Reset outputs and internal toggle pin driver
    output logic      reset_out_n,
    output logic      reset_out,
    output logic      watchdog_drive_high
);
    localparam int unsigned WD_EXT_CYCLES = WD_BASIC_CYCLES * WD_EXT_MULT;
    localparam int unsigned WD_INT_CYCLES = (WD_EXT_CYCLES / PCT_FULL) * WD_INT_PCT;

    // Elaboration checks: refuse periods the counters cannot hold and a clock too slow for the shortest toggle pulse
    if (RESET_HOLD_CYCLES < 1) begin : g_bad_hold
        $error("srw_supervisor: reset hold period must be one cycle or more");
    end
    if (WD_BASIC_CYCLES < 2) begin : g_bad_basic
        $error("srw_supervisor: basic watchdog period must be two cycles or more");
    end
    // The extended period is 500 basic periods and must fit a signed 32-bit count
    if (64'(WD_BASIC_CYCLES) * 64'(WD_EXT_MULT) >= 64'h80000000) begin : g_bad_ext
        $error("srw_supervisor: extended watchdog period overflows the counter");
    end
    // A shortest toggle pulse must reach at least two synchroniser samples
    if (MIN_PULSE_CYC < 2) begin : g_bad_pulse
        $error("srw_supervisor: clock too slow for the shortest toggle pulse");
    end

    // Every asynchronous input passes a three-stage synchroniser; a change counts
    // only once stages two and three agree, so one metastable sample is never
    // taken as a level. At 10 ns per cycle a 30 ns pulse spans three samples,
    // which is enough for the agreement test.
    // The cost is three to four cycles of latency on every input, which the
    // watchdog period has to absorb.
    localparam int unsigned NSYNC  = 5;
    localparam int unsigned SI_SUP = 0;
    localparam int unsigned SI_TOG = 1;
    localparam int unsigned SI_FLT = 2;
    localparam int unsigned SI_RNG = 3;
    localparam int unsigned SI_DIS = 4;
    // Supply starts as below trip, so reset cannot drop before the supply is seen good
    localparam logic [NSYNC-1:0] SYNC_RST = 5'h01;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_d;
    logic [NSYNC-1:0] sync_q;

    // The timing setting is inverted so that a high bit means watchdog disabled
    assign raw_in[SI_SUP] = supply_below_trip;
    assign raw_in[SI_TOG] = watchdog_toggle_in;
    assign raw_in[SI_FLT] = toggle_floating;
    assign raw_in[SI_RNG] = timeout_range_select;
    assign raw_in[SI_DIS] = ~watchdog_timing_setting;

    // One three-stage chain per input bit
    for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
        logic [2:0] stg_q;
        logic [2:0] stg_d;
        always_comb begin
            stg_d      = {stg_q[1:0], raw_in[gi]};
            sync_d[gi] = (stg_q[2] == stg_q[1]) ? stg_q[2] : sync_q[gi];
        end
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                stg_q      <= {3{SYNC_RST[gi]}};
                sync_q[gi] <= SYNC_RST[gi];
            end else begin
                stg_q      <= stg_d;
                sync_q[gi] <= sync_d[gi];
            end
        end
    end

    // Filtered levels as the rest of the block sees them
    logic sup_q;
    logic tog_q;
    logic flt_q;
    logic rng_q;
    logic dis_q;

    assign sup_q = sync_q[SI_SUP];
    assign tog_q = sync_q[SI_TOG];
    assign flt_q = sync_q[SI_FLT];
    assign rng_q = sync_q[SI_RNG];
    assign dis_q = sync_q[SI_DIS];

    // Effective toggle level: a floating pin follows the internal driver,
    // but only in extended range; in normal range the pin level is used as is.
    logic             eff_q;
    logic             eff_d;
    // Internal driver of the toggle pin in extended range
    logic             drv_q;
    logic             drv_d;
    // Range as seen one cycle earlier, for detecting a range change
    logic             rng_prev_q;
    // Supervisor state and its two counters
    srw_state_t       state_q;
    srw_state_t       state_d;
    logic [CNT_W-1:0] hold_q;
    logic [CNT_W-1:0] hold_d;
    logic [CNT_W-1:0] wd_q;
    logic [CNT_W-1:0] wd_d;
    // Registered level of the active-low reset output
    logic             rst_n_q;
    logic             rst_n_d;
    // Helper terms of the next-state logic
    logic [CNT_W-1:0] wd_limit;
    logic             edge_seen;
    logic             wd_expire;

    always_comb begin
        // A floating pin carries no level of its own; in extended range the
        // internal driver stands in for it, in normal range the pin level is used
        eff_d = (rng_q && flt_q) ? drv_q : tog_q;
        // A range change clears the timer exactly like a toggle edge
        edge_seen = (eff_d != eff_q) || (rng_q != rng_prev_q);
        wd_limit = rng_q ? CNT_W'(WD_EXT_CYCLES) : CNT_W'(WD_BASIC_CYCLES);
        // The timer starts at zero, so expiry falls after exactly limit cycles;
        // an edge in the last cycle still saves the processor.
        // Limitation: the disabled setting only blocks the expiry. The count runs
        // on, so enabling it again without a toggle edge expires at once.
        wd_expire = (state_q == SRW_RUN) && !dis_q && !edge_seen
                    && (wd_q >= wd_limit - 1'b1);
        // Internal driver rests low, pulses high one cycle at 94% of the period.
        // The pulse feeds the edge detector directly: it is narrower than the
        // input filter, so it is never taken back from the pin.
        drv_d = rng_q && (wd_q == CNT_W'(WD_INT_CYCLES));
        state_d = state_q;
        hold_d  = hold_q;
        wd_d    = wd_q;
        case (state_q)
            SRW_UNDER: begin
                // Both counters stay cleared while the supply is low
                hold_d = '0;
                wd_d   = '0;
                if (!sup_q) state_d = SRW_HOLD;
            end
            SRW_HOLD: begin
                // Counts 0 up to RESET_HOLD_CYCLES-1, so the hold lasts exactly that
                wd_d   = '0;
                hold_d = hold_q + 1'b1;
                if (hold_q >= CNT_W'(RESET_HOLD_CYCLES) - 1'b1) begin
                    state_d = SRW_RUN;
                    hold_d  = '0;
                end
            end
            SRW_RUN: begin
                // Every expiry returns to the hold, so missed services repeat the pulse
                wd_d = edge_seen ? '0 : wd_q + 1'b1;
                if (wd_expire) begin
                    state_d = SRW_HOLD;
                    wd_d    = '0;
                end
            end
            default: state_d = SRW_UNDER;
        endcase
        // A low supply overrides every state, a running hold included
        if (sup_q) state_d = SRW_UNDER;
        // Reset is released in the run state only
        rst_n_d = (state_d == SRW_RUN);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drv_q      <= 1'b0;
            eff_q      <= 1'b0;
            rng_prev_q <= 1'b0;
            state_q    <= SRW_UNDER;
            hold_q     <= '0;
            wd_q       <= '0;
            rst_n_q    <= RST_NB_RESET;
        end else begin
            drv_q      <= drv_d;
            eff_q      <= eff_d;
            rng_prev_q <= rng_q;
            state_q    <= state_d;
            hold_q     <= hold_d;
            wd_q       <= wd_d;
            rst_n_q    <= rst_n_d;
        end
    end

    // Both reset outputs come from one next-state value, rst_n_d, registered together.
    // Limitation: both are plain levels; an open-drain variant would use the
    // active-low level as its pin enable.
    logic rst_hi_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) rst_hi_q <= ~RST_NB_RESET;
        else     rst_hi_q <= ~rst_n_d;
    end

    assign reset_out_n         = rst_n_q;
    assign reset_out           = rst_hi_q;
    assign watchdog_drive_high = drv_q;
endmodule // srw_supervisor

/* File: verification/srw_supervisor_sva.sv */
// Checker for the supervisor reset outputs
`timescale 1ns/1ps
module srw_supervisor_sva
    import srw_pkg::*;
#(parameter int unsigned WD_BASIC_CYCLES = WD_BASIC_CYC) (
    // Watched ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supply_below_trip,
    input wire logic watchdog_toggle_in,
    input wire logic toggle_floating,
    input wire logic timeout_range_select,
    input wire logic watchdog_timing_setting,
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic watchdog_drive_high
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] cnt_q, cnt_d;
    logic        tog_q, rng_q;
    // Cycles since the last raw cause that may clear the timer; sync lag gives slack
    // A floating pin in normal range is left out of this count, so it clears nothing here
    always_comb cnt_d = (!reset_out_n || supply_below_trip || timeout_range_select != rng_q
        || (watchdog_toggle_in != tog_q && !(toggle_floating && !timeout_range_select)))
        ? 32'h0 : cnt_q + 32'h1;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) {cnt_q, tog_q, rng_q} <= '0;
        else {cnt_q, tog_q, rng_q} <= {cnt_d, watchdog_toggle_in, timeout_range_select};
    end
    AST_INVERSE: assert property (reset_out == !reset_out_n)
        else $error("reset outputs not inverse");
    AST_UNDER: assert property (supply_below_trip [*6] |-> !reset_out_n)
        else $error("no reset under low supply");
    AST_HOLD: assert property ($fell(reset_out_n) && !supply_below_trip |->
        !reset_out_n [*7] ##[1:3] reset_out_n) else $error("bad watchdog pulse length");
    AST_RECOVER: assert property ($rose(reset_out_n) |-> !$past(supply_below_trip, 8))
        else $error("reset released early");
    AST_EARLY: assert property ($fell(reset_out_n) && !supply_below_trip |->
        cnt_q >= WD_BASIC_CYCLES - 2) else $error("watchdog fired early");
    AST_LATE: assert property (watchdog_timing_setting && !timeout_range_select
        && cnt_q == WD_BASIC_CYCLES |-> ##[1:6] !reset_out_n) else $error("no timeout");
    AST_EXT: assert property (timeout_range_select && cnt_q == WD_BASIC_CYCLES
        * WD_EXT_MULT |-> ##[1:6] !reset_out_n) else $error("no extended timeout");
    AST_DISABLED: assert property ($fell(reset_out_n) && !supply_below_trip
        |-> watchdog_timing_setting) else $error("timeout while disabled");
    AST_DRIVE: assert property (watchdog_drive_high |->
        timeout_range_select ##1 !watchdog_drive_high) else $error("bad internal drive");
endmodule // srw_supervisor_sva
bind srw_supervisor srw_supervisor_sva #(.WD_BASIC_CYCLES(WD_BASIC_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .supply_below_trip(supply_below_trip),
    .watchdog_toggle_in(watchdog_toggle_in), .toggle_floating(toggle_floating),
    .timeout_range_select(timeout_range_select),
    .watchdog_timing_setting(watchdog_timing_setting), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .watchdog_drive_high(watchdog_drive_high));

/* File: verification/srw_cpu_model.sv */
// Processor model that services the watchdog toggle pin
`timescale 1ns/1ps
module srw_cpu_model (
    // Bench control
    input  wire logic ref_clk,
    input  wire logic service_en,
    input  wire logic float_en,
    // Supervisor side
    input  wire logic reset_out_n,
    input  wire logic watchdog_drive_high,
    output logic      watchdog_toggle_in,
    output logic      toggle_floating
);
    logic       level = 1'b0;
    logic [2:0] gap   = 3'h0;
    // Four-cycle spacing keeps each level past the minimum pulse and, with the
    // input filter's latency, still services a ten-cycle period after release
    always @(posedge ref_clk) begin
        gap <= (gap == 3'h3) ? 3'h0 : gap + 3'h1;
        if (service_en && reset_out_n && gap == 3'h3) level <= !level;
    end
    // A released pin follows the supervisor's weak internal driver
    assign watchdog_toggle_in = float_en ? watchdog_drive_high : level;
    assign toggle_floating    = float_en;
endmodule // srw_cpu_model

/* File: verification/testbench.sv */
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, rst = 1'b1, sbt = 1'b0, svc = 1'b0, flt = 1'b0;
    logic rsel    = 1'b0, wd_on = 1'b1;
    logic tog, tfl, rn, ro, drv, ok;
    int   num_errors = 0, checks_done = 0, cyc = 0;
    always #5 ref_clk = !ref_clk;
    srw_supervisor #(.RESET_HOLD_CYCLES(8), .WD_BASIC_CYCLES(10)) uut (.ref_clk(ref_clk),
        .rst(rst), .supply_below_trip(sbt), .watchdog_toggle_in(tog), .toggle_floating(tfl),
        .timeout_range_select(rsel), .watchdog_timing_setting(wd_on), .reset_out_n(rn),
        .reset_out(ro), .watchdog_drive_high(drv));
    srw_cpu_model cpu (.ref_clk(ref_clk), .service_en(svc), .float_en(flt), .reset_out_n(rn),
        .watchdog_drive_high(drv), .watchdog_toggle_in(tog), .toggle_floating(tfl));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    // Inputs move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_rn(input logic lvl, input int max);
        ok = 1'b0;
        for (int i = 0; i < max && !ok; i++) begin
            step(1);
            ok = (rn === lvl);
        end
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        step(10);
        rst = 1'b0;
        check(1'b0, rn);
        check(1'b1, ro);
        wait_rn(1'b1, 20);
        check(1'b1, ok);
        svc = 1'b1;
        step(60);
        check(1'b1, rn);
        svc = 1'b0;
        wait_rn(1'b0, 30);
        check(1'b1, ok);
        step(6);
        check(1'b0, rn);
        wait_rn(1'b1, 6);
        check(1'b1, ok);
        wait_rn(1'b0, 16);
        check(1'b1, ok);
        $display("test watchdog done");
        svc = 1'b1;
        step(20);
        sbt = 1'b1;
        step(30);
        check(1'b0, rn);
        sbt = 1'b0;
        step(8);
        check(1'b0, rn);
        wait_rn(1'b1, 8);
        check(1'b1, ok);
        $display("test supply done");
        svc   = 1'b0;
        wd_on = 1'b0;
        step(60);
        check(1'b1, rn);
        wd_on = 1'b1;
        flt   = 1'b1;
        wait_rn(1'b0, 30);
        check(1'b1, ok);
        rsel = 1'b1;
        step(6000);
        check(1'b1, rn);
        flt = 1'b0;
        svc = 1'b1;
        step(6);
        svc = 1'b0;
        step(4494);
        check(1'b1, rn);
        wait_rn(1'b0, 1000);
        check(1'b1, ok);
        $display("test range done");
        test_done();
    end
endmodule // testbench
